// ===== logic/msd_pkg.sv
// How it works
// - first fetch after reset from address zero
// - each interrupt source jumps to fixed entry
// - external interrupt zero enters at address three
// - entry slots spaced eight bytes apart
// - unused entry slots are plain program storage
// - 16-bit counter, 8K bytes implemented
// - program store read only by instruction fetch
// - 256 byte read-write internal data space
// - above 7Fh: direct to sfr, indirect upper
// - upper 128 bytes reached only indirectly
// - lower 128 reachable direct and indirect
// - lowest 32 bytes: four banks, eight registers
// - two status bits choose register bank
// - bank select at status bits four, three
// - 16 bytes above banks are bit-addressable
// - data pointer forms 16-bit data addresses
// - 512 byte eeprom reached through sfr bytes
package msd_pkg;

    // ****************************************************************
    // program space
    // ****************************************************************
    localparam int          PC_W         = 16;
    localparam int          PROG_AW      = 13;
    localparam int          PROG_BYTES   = 8192;
    localparam logic [15:0] RESET_VECTOR = 16'h0000;
    localparam logic [15:0] IRQ_VEC_BASE = 16'h0003;
    localparam logic [15:0] IRQ_VEC_STEP = 16'h0008;
    localparam int          IRQ_SRC_W    = 3;
    localparam logic [7:0]  PROG_FILL    = 8'hff;

    // ****************************************************************
    // internal data space
    // ****************************************************************
    localparam logic [7:0]  DATA_LOW_TOP  = 8'h7f;
    localparam logic [7:0]  BIT_AREA_BASE = 8'h20;
    localparam int          HALF_BYTES    = 128;

    // ****************************************************************
    // special-function space, internal registers
    // ****************************************************************
    localparam logic [7:0]  SFR_DPL       = 8'h82;
    localparam logic [7:0]  SFR_DPH       = 8'h83;
    localparam logic [7:0]  SFR_EE_ADDR_L = 8'h92;
    localparam logic [7:0]  SFR_EE_ADDR_H = 8'h93;
    localparam logic [7:0]  SFR_EE_DATA   = 8'h94;
    localparam logic [7:0]  SFR_EE_CTRL   = 8'h95;
    localparam logic [7:0]  SFR_PSW       = 8'hd0;
    localparam int          PSW_BANK_HI   = 4;
    localparam int          PSW_BANK_LO   = 3;
    localparam logic [7:0]  PSW_RESET     = 8'h00;
    localparam logic [15:0] DATA_POINTER_RESET    = 16'h0000;

    // ****************************************************************
    // eeprom data store
    // ****************************************************************
    localparam int          EE_AW         = 9;
    localparam int          EE_BYTES      = 512;
    localparam int          EE_CTRL_WR    = 0;
    localparam int          EE_CTRL_RD    = 1;
    localparam logic [8:0]  EE_ADDR_RESET = 9'h000;
    localparam logic [7:0]  EE_DATA_RESET = 8'h00;

    // ****************************************************************
    // types
    // ****************************************************************
    typedef enum logic [1:0] {
        MODE_DIRECT,
        MODE_INDIRECT,
        MODE_REG,
        MODE_BIT
    } msd_mode_t;

    typedef enum logic [1:0] {
        TGT_LOW,
        TGT_UPPER,
        TGT_SFR
    } msd_target_t;

endpackage : msd_pkg

// ===== logic/msd_program_store.sv
`timescale 1ns/1ps
module msd_program_store (
    input  wire logic        clk_i,
    input  wire logic        prog_we_i,
    input  wire logic [12:0] prog_waddr_i,
    input  wire logic [7:0]  prog_wdata_i,
    input  wire logic        rd_en_i,
    input  wire logic [15:0] rd_addr_i,
    output logic      [7:0]  rd_data_o
);

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [7:0] mem [msd_pkg::PROG_BYTES];
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic       in_range;

    // loading only through the programming port, never from data side
    always_ff @(posedge clk_i) begin
        if (prog_we_i) begin
            mem[prog_waddr_i] <= prog_wdata_i;
        end
    end

    // ****************************************************************
    // read, holds last value when idle
    // ****************************************************************
    always_comb begin
        in_range  = (rd_addr_i[15:msd_pkg::PROG_AW] == '0);
        rd_data_d = rd_data_q;
        if (rd_en_i) begin
            rd_data_d = in_range ? mem[rd_addr_i[msd_pkg::PROG_AW-1:0]] : msd_pkg::PROG_FILL;
        end
    end

    always_ff @(posedge clk_i) begin
        rd_data_q <= rd_data_d;
    end

    assign rd_data_o = rd_data_q;

endmodule : msd_program_store

// ===== logic/msd_memory_space_decode.sv
`timescale 1ns/1ps
module msd_memory_space_decode (
    input  wire logic                      clk_i,
    input  wire logic                      nrst_i,
    // instruction fetch
    input  wire logic                      fetch_req_i,
    input  wire logic                      jump_i,
    input  wire logic [15:0]               jump_addr_i,
    input  wire logic                      irq_take_i,
    input  wire logic [2:0]                irq_src_i,
    output logic      [15:0]               fetch_addr_o,
    output logic      [7:0]                fetch_data_o,
    output logic                           fetch_valid_o,
    // programming port of the program store
    input  wire logic                      prog_we_i,
    input  wire logic [12:0]               prog_waddr_i,
    input  wire logic [7:0]                prog_wdata_i,
    // internal data access
    input  wire logic                      data_req_i,
    input  wire logic                      data_we_i,
    input  wire logic [1:0]                data_mode_i,
    input  wire logic [7:0]                data_addr_i,
    input  wire logic [7:0]                data_wdata_i,
    output logic      [7:0]                data_rdata_o,
    output logic                           data_ack_o,
    // external special-function registers
    output logic                           sfr_req_o,
    output logic                           sfr_we_o,
    output logic      [7:0]                sfr_addr_o,
    output logic      [7:0]                sfr_wdata_o,
    input  wire logic [7:0]                sfr_rdata_i,
    // data pointer and status
    input  wire logic                      data_pointer_inc_i,
    output logic      [15:0]               data_pointer_o,
    output logic      [7:0]                processor_status_word_o
);

    // ****************************************************************
    // decode functions
    // ****************************************************************
    function automatic msd_pkg::msd_target_t decode_target(input msd_pkg::msd_mode_t mode,
                                                          input logic [7:0] addr);
        msd_pkg::msd_target_t t;
        t = msd_pkg::TGT_LOW;
        if (addr > msd_pkg::DATA_LOW_TOP) begin
            unique case (mode)
                msd_pkg::MODE_INDIRECT: t = msd_pkg::TGT_UPPER;
                msd_pkg::MODE_DIRECT:   t = msd_pkg::TGT_SFR;
                msd_pkg::MODE_BIT:      t = msd_pkg::TGT_SFR;
                msd_pkg::MODE_REG:      t = msd_pkg::TGT_LOW;
            endcase
        end
        return t;
    endfunction : decode_target

    function automatic logic [7:0] decode_byte(input msd_pkg::msd_mode_t mode,
                                               input logic [7:0] addr,
                                               input logic [1:0] bank);
        logic [7:0] b;
        b = addr;
        unique case (mode)
            msd_pkg::MODE_REG: b = {3'h0, bank, addr[2:0]};
            msd_pkg::MODE_BIT: begin
                if (addr > msd_pkg::DATA_LOW_TOP) begin
                    b = {addr[7:3], 3'h0};
                end else begin
                    b = msd_pkg::BIT_AREA_BASE + {4'h0, addr[6:3]};
                end
            end
            default: b = addr;
        endcase
        return b;
    endfunction : decode_byte

    function automatic logic sfr_internal(input logic [7:0] addr);
        return (addr == msd_pkg::SFR_PSW) || (addr == msd_pkg::SFR_DPL) ||
               (addr == msd_pkg::SFR_DPH) || (addr == msd_pkg::SFR_EE_ADDR_L) ||
               (addr == msd_pkg::SFR_EE_ADDR_H) || (addr == msd_pkg::SFR_EE_DATA) ||
               (addr == msd_pkg::SFR_EE_CTRL);
    endfunction : sfr_internal

    // ****************************************************************
    // storage
    // ****************************************************************
    logic [7:0]           ram_low   [msd_pkg::HALF_BYTES];
    logic [7:0]           ram_upper [msd_pkg::HALF_BYTES];
    logic [7:0]           ee_mem    [msd_pkg::EE_BYTES];

    // ****************************************************************
    // state
    // ****************************************************************
    logic [15:0]          pc_q;
    logic [15:0]          pc_d;
    logic                 fetch_valid_q;
    logic                 fetch_valid_d;
    logic [7:0]           psw_q;
    logic [7:0]           psw_d;
    logic [15:0]          data_pointer_q;
    logic [15:0]          data_pointer_d;
    logic [8:0]           ee_addr_q;
    logic [8:0]           ee_addr_d;
    logic [7:0]           ee_data_q;
    logic [7:0]           ee_data_d;
    logic [7:0]           rdata_q;
    logic [7:0]           rdata_d;
    logic                 ack_q;
    logic                 ack_d;

    // ****************************************************************
    // combinational decode signals
    // ****************************************************************
    msd_pkg::msd_mode_t   mode;
    msd_pkg::msd_target_t tgt;
    logic [7:0]           byte_addr;
    logic [2:0]           bit_idx;
    logic                 is_bit;
    logic                 int_sfr;
    logic [7:0]           cur_byte;
    logic [7:0]           new_byte;
    logic                 do_wr;
    logic                 low_we;
    logic                 upper_we;
    logic                 ee_we;
    logic [15:0]          vector;

    // ****************************************************************
    // program counter
    // ****************************************************************
    // interrupt outranks jump, jump outranks fetch
    always_comb begin
        vector        = msd_pkg::IRQ_VEC_BASE + 16'(irq_src_i) * msd_pkg::IRQ_VEC_STEP;
        pc_d          = pc_q;
        fetch_valid_d = fetch_req_i;
        if (irq_take_i) begin
            pc_d          = vector;
            fetch_valid_d = 1'b0;
        end else if (jump_i) begin
            pc_d          = jump_addr_i;
            fetch_valid_d = 1'b0;
        end else if (fetch_req_i) begin
            pc_d = pc_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pc_q          <= msd_pkg::RESET_VECTOR;
            fetch_valid_q <= 1'b0;
        end else begin
            pc_q          <= pc_d;
            fetch_valid_q <= fetch_valid_d;
        end
    end

    // ****************************************************************
    // program store
    // ****************************************************************
    msd_program_store u_program_store (
        .clk_i        (clk_i),
        .prog_we_i    (prog_we_i),
        .prog_waddr_i (prog_waddr_i),
        .prog_wdata_i (prog_wdata_i),
        .rd_en_i      (fetch_valid_d),
        .rd_addr_i    (pc_q),
        .rd_data_o    (fetch_data_o)
    );

    assign fetch_addr_o  = pc_q;
    assign fetch_valid_o = fetch_valid_q;

    // ****************************************************************
    // data access decode and read
    // ****************************************************************
    always_comb begin
        mode      = msd_pkg::msd_mode_t'(data_mode_i);
        tgt       = decode_target(mode, data_addr_i);
        byte_addr = decode_byte(mode, data_addr_i, {psw_q[msd_pkg::PSW_BANK_HI],
                                                    psw_q[msd_pkg::PSW_BANK_LO]});
        bit_idx   = data_addr_i[2:0];
        is_bit    = (mode == msd_pkg::MODE_BIT);
        int_sfr   = (tgt == msd_pkg::TGT_SFR) && sfr_internal(byte_addr);
        cur_byte  = 8'h00;
        unique case (tgt)
            msd_pkg::TGT_LOW:   cur_byte = ram_low[byte_addr[6:0]];
            msd_pkg::TGT_UPPER: cur_byte = ram_upper[byte_addr[6:0]];
            default: begin
                if (!int_sfr) begin
                    cur_byte = sfr_rdata_i;
                end else if (byte_addr == msd_pkg::SFR_PSW) begin
                    cur_byte = psw_q;
                end else if (byte_addr == msd_pkg::SFR_DPL) begin
                    cur_byte = data_pointer_q[7:0];
                end else if (byte_addr == msd_pkg::SFR_DPH) begin
                    cur_byte = data_pointer_q[15:8];
                end else if (byte_addr == msd_pkg::SFR_EE_ADDR_L) begin
                    cur_byte = ee_addr_q[7:0];
                end else if (byte_addr == msd_pkg::SFR_EE_ADDR_H) begin
                    cur_byte = {7'h00, ee_addr_q[8]};
                end else if (byte_addr == msd_pkg::SFR_EE_DATA) begin
                    cur_byte = ee_data_q;
                end
            end
        endcase
        // bit writes are a read-modify-write of the holding byte
        new_byte          = is_bit ? cur_byte : data_wdata_i;
        new_byte[bit_idx] = is_bit ? data_wdata_i[0] : data_wdata_i[bit_idx];
        do_wr    = data_req_i && data_we_i;
        low_we   = do_wr && (tgt == msd_pkg::TGT_LOW);
        upper_we = do_wr && (tgt == msd_pkg::TGT_UPPER);
        ack_d    = data_req_i;
        rdata_d  = rdata_q;
        if (data_req_i && !data_we_i) begin
            rdata_d = is_bit ? {7'h00, cur_byte[bit_idx]} : cur_byte;
        end
    end

    // ****************************************************************
    // external special-function port
    // ****************************************************************
    // far side answers in the same cycle
    assign sfr_req_o   = data_req_i && (tgt == msd_pkg::TGT_SFR) && !int_sfr;
    assign sfr_we_o    = sfr_req_o && data_we_i;
    assign sfr_addr_o  = byte_addr;
    assign sfr_wdata_o = new_byte;

    // ****************************************************************
    // data memories
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (low_we) begin
            ram_low[byte_addr[6:0]] <= new_byte;
        end
        if (upper_we) begin
            ram_upper[byte_addr[6:0]] <= new_byte;
        end
    end

    // ****************************************************************
    // internal special-function registers
    // ****************************************************************
    always_comb begin
        psw_d     = psw_q;
        data_pointer_d    = data_pointer_q;
        ee_addr_d = ee_addr_q;
        ee_data_d = ee_data_q;
        ee_we     = 1'b0;
        if (data_pointer_inc_i) begin
            data_pointer_d = data_pointer_q + 16'h0001;
        end
        if (do_wr && int_sfr) begin
            unique case (byte_addr)
                msd_pkg::SFR_PSW:       psw_d         = new_byte;
                msd_pkg::SFR_DPL:       data_pointer_d[7:0]   = new_byte;
                msd_pkg::SFR_DPH:       data_pointer_d[15:8]  = new_byte;
                msd_pkg::SFR_EE_ADDR_L: ee_addr_d[7:0] = new_byte;
                msd_pkg::SFR_EE_ADDR_H: ee_addr_d[8]   = new_byte[0];
                msd_pkg::SFR_EE_DATA:   ee_data_d     = new_byte;
                msd_pkg::SFR_EE_CTRL: begin
                    // write start wins when both strobes are set
                    if (new_byte[msd_pkg::EE_CTRL_WR]) begin
                        ee_we = 1'b1;
                    end else if (new_byte[msd_pkg::EE_CTRL_RD]) begin
                        ee_data_d = ee_mem[ee_addr_q];
                    end
                end
                default: psw_d = psw_q;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            psw_q     <= msd_pkg::PSW_RESET;
            data_pointer_q    <= msd_pkg::DATA_POINTER_RESET;
            ee_addr_q <= msd_pkg::EE_ADDR_RESET;
            ee_data_q <= msd_pkg::EE_DATA_RESET;
            rdata_q   <= 8'h00;
            ack_q     <= 1'b0;
        end else begin
            psw_q     <= psw_d;
            data_pointer_q    <= data_pointer_d;
            ee_addr_q <= ee_addr_d;
            ee_data_q <= ee_data_d;
            rdata_q   <= rdata_d;
            ack_q     <= ack_d;
        end
    end

    // ****************************************************************
    // eeprom array
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (ee_we) begin
            ee_mem[ee_addr_q] <= ee_data_q;
        end
    end

    assign data_rdata_o            = rdata_q;
    assign data_ack_o              = ack_q;
    assign data_pointer_o          = data_pointer_q;
    assign processor_status_word_o = psw_q;

endmodule : msd_memory_space_decode

// ===== dv/msd_sfr_model.sv
`timescale 1ns/1ps
module msd_sfr_model (
    input  wire logic       clk_i,
    input  wire logic       req_i,
    input  wire logic       we_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o
);
    // ****************
    // external special-function registers
    // ****************
    logic [7:0] regs_q [128];
    logic [7:0] last_q;
    // a deselected bus shows the inverse of the last value, never a stale copy
    assign rdata_o = req_i ? regs_q[addr_i[6:0]] : ~last_q;
    always_ff @(posedge clk_i) begin
        if (req_i && we_i) begin
            regs_q[addr_i[6:0]] <= wdata_i;
        end
        last_q <= rdata_o;
    end
endmodule : msd_sfr_model

// ===== dv/msd_assertions.sv
`timescale 1ns/1ps
module msd_checker (
    input wire logic        clk_i,
    input wire logic        nrst_i,
    input wire logic        fetch_req_i,
    input wire logic        jump_i,
    input wire logic [15:0] jump_addr_i,
    input wire logic        irq_take_i,
    input wire logic [2:0]  irq_src_i,
    input wire logic [15:0] fetch_addr_o,
    input wire logic [7:0]  fetch_data_o,
    input wire logic        fetch_valid_o,
    input wire logic        data_req_i,
    input wire logic        data_we_i,
    input wire logic [1:0]  data_mode_i,
    input wire logic [7:0]  data_addr_i,
    input wire logic        data_ack_o,
    input wire logic        sfr_req_o,
    input wire logic        sfr_we_o,
    input wire logic [7:0]  sfr_addr_o
);
    // ****************
    // assertions
    // ****************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    logic int_sfr;
    assign int_sfr = data_addr_i inside {8'h82, 8'h83, 8'h92, 8'h93, 8'h94, 8'h95, 8'hd0};
    sequence fetch_s;
        fetch_req_i && !irq_take_i && !jump_i;
    endsequence
    sequence far_s;
        fetch_s ##0 (fetch_addr_o[15:13] != 3'h0);
    endsequence
    reset_entry_a: assert property ($rose(nrst_i) |-> fetch_addr_o == 16'h0000)
        else $error("pc not at zero after reset");
    fetch_valid_a: assert property (fetch_s |=> fetch_valid_o)
        else $error("fetch not answered");
    pc_step_a: assert property (fetch_s |=> fetch_addr_o == $past(fetch_addr_o) + 16'h0001)
        else $error("pc did not step");
    irq_vec_a: assert property (irq_take_i |=> fetch_addr_o == 16'h0003 + {$past(irq_src_i), 3'h0})
        else $error("wrong interrupt entry");
    irq_zero_a: assert property (irq_take_i && irq_src_i == 3'h0 |=> fetch_addr_o == 16'h0003)
        else $error("wrong entry for source zero");
    jump_load_a: assert property (jump_i && !irq_take_i |=> fetch_addr_o == $past(jump_addr_i))
        else $error("jump not loaded");
    far_fill_a: assert property (far_s |=> fetch_data_o == 8'hff)
        else $error("fetch beyond store not fill value");
    data_ack_a: assert property (data_req_i |=> data_ack_o)
        else $error("access not acknowledged");
    ack_idle_a: assert property (!data_req_i |=> !data_ack_o)
        else $error("acknowledge without access");
    sfr_route_a: assert property (data_req_i && data_mode_i == 2'h0 && data_addr_i[7] && !int_sfr
        |-> sfr_req_o && sfr_we_o == data_we_i && sfr_addr_o == data_addr_i)
        else $error("direct high access not sent out");
    upper_only_a: assert property (data_req_i && data_mode_i == 2'h1 |-> !sfr_req_o)
        else $error("indirect access reached sfr");
endmodule : msd_checker
bind msd_memory_space_decode msd_checker msd_checker_inst (.clk_i, .nrst_i, .fetch_req_i, .jump_i,
    .jump_addr_i, .irq_take_i, .irq_src_i, .fetch_addr_o, .fetch_data_o, .fetch_valid_o, .data_req_i,
    .data_we_i, .data_mode_i, .data_addr_i, .data_ack_o, .sfr_req_o, .sfr_we_o, .sfr_addr_o);

// ===== dv/msd_memory_space_decode_tb_top.sv
`timescale 1ns/1ps
module msd_memory_space_decode_tb_top;
    logic        clk_i, nrst_i, fetch_req_i, jump_i, irq_take_i, prog_we_i, data_req_i, data_we_i;
    logic        data_pointer_inc_i, fetch_valid_o, data_ack_o, sfr_req_o, sfr_we_o;
    logic [1:0]  data_mode_i;
    logic [2:0]  irq_src_i;
    logic [7:0]  prog_wdata_i, data_addr_i, data_wdata_i, fetch_data_o, data_rdata_o, a, d;
    logic [7:0]  sfr_addr_o, sfr_wdata_o, sfr_rdata_i, processor_status_word_o;
    logic [12:0] prog_waddr_i;
    logic [15:0] jump_addr_i, fetch_addr_o, data_pointer_o;
    logic [7:0]  pm [65];
    logic [8:0]  dq [$];
    logic [8:0]  e;
    logic [7:0]  fq [$];
    int          err_count, cmp_count, cyc;
    msd_memory_space_decode msd_memory_space_decode_inst (.clk_i, .nrst_i, .fetch_req_i, .jump_i,
        .jump_addr_i, .irq_take_i, .irq_src_i, .fetch_addr_o, .fetch_data_o, .fetch_valid_o, .prog_we_i,
        .prog_waddr_i, .prog_wdata_i, .data_req_i, .data_we_i, .data_mode_i, .data_addr_i, .data_wdata_i,
        .data_rdata_o, .data_ack_o, .sfr_req_o, .sfr_we_o, .sfr_addr_o, .sfr_wdata_o, .sfr_rdata_i,
        .data_pointer_inc_i, .data_pointer_o, .processor_status_word_o);
    msd_sfr_model msd_sfr_model_inst (.clk_i, .req_i(sfr_req_o), .we_i(sfr_we_o), .addr_i(sfr_addr_o),
        .wdata_i(sfr_wdata_o), .rdata_o(sfr_rdata_i));
    // ****************
    // helpers
    // ****************
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test
    task automatic rel;
        @(posedge clk_i);
        {fetch_req_i, jump_i, irq_take_i, prog_we_i, data_req_i, data_pointer_inc_i} <= 6'h00;
        @(negedge clk_i);
    endtask : rel
    task automatic acc(input logic w, input logic [1:0] m, input logic [7:0] ad, input logic [7:0] dt);
        @(posedge clk_i);
        data_req_i   <= 1'b1;
        data_we_i    <= w;
        data_mode_i  <= m;
        data_addr_i  <= ad;
        data_wdata_i <= dt;
        dq.push_back({~w, dt});
    endtask : acc
    task automatic fe(input logic [7:0] x);
        @(posedge clk_i);
        fetch_req_i <= 1'b1;
        fq.push_back(x);
    endtask : fe
    task automatic ctl(input logic j, input logic [15:0] ad, input logic [2:0] s);
        @(posedge clk_i);
        fetch_req_i <= 1'b0;
        jump_i      <= j;
        irq_take_i  <= ~j;
        jump_addr_i <= ad;
        irq_src_i   <= s;
        rel();
    endtask : ctl
    // ****************
    // clock, watchdog and result monitor
    // ****************
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            end_of_test();
        end
    end
    always @(negedge clk_i) begin
        if (data_ack_o === 1'b1) begin
            chk(16'(dq.size() != 0), 16'h0001);
            e = dq.pop_front();
            if (e[8]) chk(16'(data_rdata_o), 16'(e[7:0]));
        end
        if (fetch_valid_o === 1'b1) chk(16'(fetch_data_o), 16'(fq.pop_front()));
    end
    // ****************
    // tests
    // ****************
    initial begin
        void'($urandom(25270));
        {nrst_i, fetch_req_i, jump_i, irq_take_i, prog_we_i, data_req_i, data_we_i, data_pointer_inc_i} = 8'h00;
        {data_mode_i, irq_src_i, prog_waddr_i, prog_wdata_i, data_addr_i, data_wdata_i, jump_addr_i} = '0;
        foreach (pm[i]) pm[i] = 8'($urandom);
        repeat (16) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        chk(fetch_addr_o, 16'h0000);
        chk({processor_status_word_o, data_pointer_o[7:0]}, 16'h0000);
        for (int i = 0; i < 65; i++) begin
            @(posedge clk_i);
            prog_we_i    <= 1'b1;
            prog_waddr_i <= (i < 64) ? 13'(i) : 13'h1fff;
            prog_wdata_i <= pm[i];
        end
        rel();
        fe(pm[0]);
        fe(pm[1]);
        fe(pm[2]);
        rel();
        for (int s = 0; s < 8; s++) begin
            ctl(1'b0, 16'h0000, 3'(s));
            chk(fetch_addr_o, 16'h0003 + 16'(8 * s));
            fe(pm[3 + 8 * s]);
            rel();
        end
        $display("test vectors done");
        ctl(1'b1, 16'h1fff, 3'h0);
        fe(pm[64]);
        fe(8'hff);
        rel();
        ctl(1'b1, 16'hfff0, 3'h0);
        fe(8'hff);
        rel();
        $display("test program range done");
        for (int i = 0; i < 4; i++) begin
            a = 8'h40 | 8'($urandom & 32'h3f);
            d = 8'($urandom);
            acc(1'b1, 2'h0, a, d);
            acc(1'b0, 2'h1, a, d);
            acc(1'b1, 2'h1, a, ~d);
            acc(1'b0, 2'h0, a, ~d);
        end
        a = 8'($urandom);
        d = 8'($urandom);
        acc(1'b1, 2'h1, 8'h90, a);
        acc(1'b1, 2'h0, 8'h90, d);
        acc(1'b0, 2'h1, 8'h90, a);
        acc(1'b0, 2'h0, 8'h90, d);
        acc(1'b1, 2'h3, 8'h93, 8'h01);
        acc(1'b0, 2'h0, 8'h90, d | 8'h08);
        acc(1'b1, 2'h1, 8'hff, ~a);
        acc(1'b0, 2'h1, 8'hff, ~a);
        $display("test data spaces done");
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            acc(1'b1, 2'h0, 8'hd0, 8'(k << 3));
            acc(1'b1, 2'h2, 8'hf7, d);
            acc(1'b0, 2'h1, 8'(8 * k + 7), d);
        end
        acc(1'b0, 2'h0, 8'hd0, 8'h18);
        rel();
        chk(16'(processor_status_word_o), 16'h0018);
        acc(1'b1, 2'h0, 8'h21, 8'h00);
        acc(1'b1, 2'h3, 8'h0d, 8'h01);
        acc(1'b0, 2'h0, 8'h21, 8'h20);
        acc(1'b0, 2'h3, 8'h0d, 8'h01);
        $display("test banks and bits done");
        acc(1'b1, 2'h0, 8'h82, 8'hff);
        acc(1'b1, 2'h0, 8'h83, 8'h3c);
        rel();
        chk(data_pointer_o, 16'h3cff);
        @(posedge clk_i);
        data_pointer_inc_i <= 1'b1;
        rel();
        chk(data_pointer_o, 16'h3d00);
        a = 8'($urandom);
        for (int h = 1; h >= 0; h--) begin
            acc(1'b1, 2'h0, 8'h92, 8'ha5);
            acc(1'b1, 2'h0, 8'h93, 8'(h));
            acc(1'b1, 2'h0, 8'h94, a ^ 8'(h));
            acc(1'b1, 2'h0, 8'h95, 8'h01);
        end
        for (int h = 1; h >= 0; h--) begin
            acc(1'b1, 2'h0, 8'h93, 8'(h));
            acc(1'b1, 2'h0, 8'h95, 8'h02);
            rel();
            acc(1'b0, 2'h0, 8'h94, a ^ 8'(h));
            acc(1'b0, 2'h0, 8'h95, 8'h00);
        end
        rel();
        ctl(1'b1, 16'h0000, 3'h0);
        fe(pm[0]);
        rel();
        rel();
        $display("test pointer and eeprom done");
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        nrst_i <= 1'b1;
        @(negedge clk_i);
        chk(fetch_addr_o, 16'h0000);
        chk(16'(processor_status_word_o), 16'h0000);
        fe(pm[0]);
        rel();
        rel();
        $display("test second reset done");
        chk(16'(dq.size() + fq.size()), 16'h0000);
        end_of_test();
    end
endmodule : msd_memory_space_decode_tb_top
